// *** hw/iafcc_ctrl.sv ***
// Top of the in-application flash command controller: mailbox
// registers, command decode, lock checks and operation sequencing.
// Assumes the CPU drives the plain register port on sys_clk.
//
// Summary of operation
// - Commands ignored unless IAP enable set
// - Only command mailbox write starts operations
// - Locked block refuses erase, program and verify; chip erase, security and remap bit commands still run
// - 01H key 55H erases all, clears bits
// - 0DH key 55H erases selected block
// - 0BH erases addressed 128/64 byte sector
// - 0EH programs one data byte
// - 06H programs bytes within one row
// - During burst, other commands and reads invalid
// - 0CH reads byte into data, no interrupt
// - Security bit commands take effect immediately
// - Remap bits affect mapping after reset
// - Status bit 2 high while operation runs
// - Status bit 3 drops between burst bytes
// - Code reads to busy block fail
// - Command bit 7 routes completion interrupt internally
// - Completion interrupt needs enables and edge mode
// - Timing oscillator runs only during operations
// - Burst ends on new row, command, timeout between bytes
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "iafcc_consts.svh"
module iafcc_ctrl #(
    parameter int AW = 16,
    parameter int DEPTH = 64,
    parameter int BLK1_BASE = 16'hF000,
    parameter logic [15:0] PROG_CYC = 16'h0019,
    parameter logic [15:0] ERASE_CYC = 16'h0064,
    parameter logic [15:0] BURST_TO_CYC = 16'(`IAFCC_BURST_TO_CYC)
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic [AW-1:0] codeAddr,
    input wire logic codeRdEn,
    output logic [7:0] codeRdData,
    output logic codeRdFail,
    input wire logic lineBEdgeSelect,
    input wire logic lineBInterruptEnable,
    input wire logic globalInterruptEnable,
    input wire logic externalInterruptLineB,
    output logic lineBInterrupt,
    output logic lineBPinAsPort,
    output logic [1:0] mapEnable,
    output logic oscEnable
);
    // ==========================================================
    // Mailbox registers
    logic [7:0] addrLow;
    logic [7:0] addrHigh;
    logic [7:0] dataMbox;
    logic [7:0] cmdMbox;
    logic [7:0] configMbox;
    logic [2:0] secBits;
    logic [1:0] remapBits;
    logic flashBusy;
    logic byteBusy;
    logic doneEvent;
    logic verifyLoad;
    logic [15:0] burstTimer;
    logic [AW-1:0] rowBase;
    iafcc_pkg::iafcc_state_t state;
    iafcc_pkg::iafcc_kind_t kind;

    iafcc_mem_if #(.AW(AW)) mem ();

    logic timerDone;
    logic [15:0] timerTarget;

    iafcc_osc_timer #(.W(16)) u_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .oscEn(oscEnable),
        .target(timerTarget),
        .done(timerDone),
        .running()
    );

    iafcc_flash_array #(.AW(AW), .DEPTH(DEPTH)) u_array (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .mem(mem)
    );

    // ==========================================================
    // Command decode
    wire logic [AW-1:0] mboxAddr = AW'({addrHigh, addrLow});
    wire logic cmdWrite = regWrEn && regAddr == `IAFCC_OFF_CMD;
    wire logic [6:0] op = regWrData[6:0];
    wire logic iapEnabled = configMbox[`IAFCC_CFG_IAP_EN];
    wire logic selBlk1 = addrHigh[7:4] == `IAFCC_BLK1_NIB;
    wire logic keyOk = dataMbox == `IAFCC_KEY_DATA;
    wire logic bitKeyOk = keyOk && addrHigh == `IAFCC_KEY_ADDRH;
    // Programmed SB1 locks both blocks; SB2/SB3 alone
    // lock block 1 only.
    wire logic blk0Locked = secBits[0];
    wire logic blk1Locked = |secBits;
    wire logic selLocked = selBlk1 ? blk1Locked : blk0Locked;
    wire logic inBurst = state == iafcc_pkg::IAFCC_BURST_WAIT ||
        state == iafcc_pkg::IAFCC_BURST_PROG;
    wire logic [AW-1:0] rowMask = selBlk1 ? AW'(16'hFFE0) :
        AW'(16'hFFC0);
    wire logic sameRow = (mboxAddr & rowMask) == rowBase;

    logic accept;
    iafcc_pkg::iafcc_kind_t next_kind;
    always_comb begin
        accept = 1'b0;
        next_kind = iafcc_pkg::IAFCC_K_BYTE;
        if (cmdWrite && iapEnabled && !inBurst && !flashBusy) begin
            if (op == `IAFCC_OP_CHIP_ERASE) begin
                accept = keyOk;
                next_kind = iafcc_pkg::IAFCC_K_CHIP;
            end else if (op == `IAFCC_OP_BLOCK_ERASE) begin
                accept = keyOk && !selLocked;
                next_kind = iafcc_pkg::IAFCC_K_BLOCK;
            end else if (op == `IAFCC_OP_SECTOR_ERASE) begin
                accept = !selLocked;
                next_kind = iafcc_pkg::IAFCC_K_SECTOR;
            end else if (op == `IAFCC_OP_BYTE_PROG) begin
                accept = !selLocked;
                next_kind = iafcc_pkg::IAFCC_K_BYTE;
            end else if (op == `IAFCC_OP_BURST_PROG) begin
                accept = !selLocked;
                next_kind = iafcc_pkg::IAFCC_K_BURST;
            end else if (op == `IAFCC_OP_SB1 || op == `IAFCC_OP_SB2 ||
                    op == `IAFCC_OP_SB3) begin
                accept = bitKeyOk;
                next_kind = iafcc_pkg::IAFCC_K_SECBIT;
            end else if (op == `IAFCC_OP_RB1 || op == `IAFCC_OP_RB0) begin
                accept = bitKeyOk;
                next_kind = iafcc_pkg::IAFCC_K_REMAP;
            end
            // Unlisted codes fall through with accept low
        end
    end

    wire logic verifyCmd = cmdWrite && iapEnabled && !inBurst &&
        op == `IAFCC_OP_VERIFY && !selLocked;
    wire logic burstNext = cmdWrite && iapEnabled &&
        state == iafcc_pkg::IAFCC_BURST_WAIT &&
        op == `IAFCC_OP_BURST_PROG && sameRow;
    // Any other command written while a burst waits for its next byte closes it
    wire logic burstBreak = state == iafcc_pkg::IAFCC_BURST_WAIT &&
        ((cmdWrite && !burstNext) || burstTimer == BURST_TO_CYC);

    // ==========================================================
    // Sequencer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= iafcc_pkg::IAFCC_IDLE;
            kind <= iafcc_pkg::IAFCC_K_BYTE;
        end else begin
            case (state)
                iafcc_pkg::IAFCC_IDLE: begin
                    if (accept) begin
                        kind <= next_kind;
                        state <= iafcc_pkg::IAFCC_EXEC;
                    end
                end
                iafcc_pkg::IAFCC_EXEC: begin
                    if (timerDone) begin
                        state <= kind == iafcc_pkg::IAFCC_K_BURST ?
                            iafcc_pkg::IAFCC_BURST_WAIT :
                            iafcc_pkg::IAFCC_FINISH;
                    end
                end
                iafcc_pkg::IAFCC_BURST_WAIT: begin
                    if (burstNext) begin
                        state <= iafcc_pkg::IAFCC_BURST_PROG;
                    end else if (burstBreak) begin
                        state <= iafcc_pkg::IAFCC_FINISH;
                    end
                end
                iafcc_pkg::IAFCC_BURST_PROG: begin
                    if (timerDone) begin
                        state <= iafcc_pkg::IAFCC_BURST_WAIT;
                    end
                end
                default: begin
                    state <= iafcc_pkg::IAFCC_IDLE;
                end
            endcase
        end
    end

    // Oscillator on only while an operation is timed
    assign oscEnable = state == iafcc_pkg::IAFCC_EXEC ||
        state == iafcc_pkg::IAFCC_BURST_PROG;
    assign timerTarget = (kind == iafcc_pkg::IAFCC_K_BYTE ||
        kind == iafcc_pkg::IAFCC_K_BURST) ? PROG_CYC : ERASE_CYC;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || state != iafcc_pkg::IAFCC_BURST_WAIT) begin
            burstTimer <= 16'h0000;
        end else begin
            burstTimer <= burstTimer + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rowBase <= '0;
        end else if (accept && next_kind == iafcc_pkg::IAFCC_K_BURST) begin
            rowBase <= mboxAddr & rowMask;
        end
    end

    // ==========================================================
    // Array access
    wire logic opEnd = state == iafcc_pkg::IAFCC_EXEC && timerDone;
    wire logic isProg = kind == iafcc_pkg::IAFCC_K_BYTE ||
        kind == iafcc_pkg::IAFCC_K_BURST;
    wire logic [AW-1:0] blk1Base = AW'(BLK1_BASE);
    wire logic [AW-1:0] secMask = selBlk1 ? AW'(16'hFFC0) :
        AW'(16'hFF80);

    assign mem.wrEn = (opEnd && isProg) ||
        (state == iafcc_pkg::IAFCC_BURST_PROG && timerDone);
    assign mem.wrAddr = mboxAddr;
    assign mem.wrData = dataMbox;
    assign mem.eraseEn = opEnd && (kind == iafcc_pkg::IAFCC_K_CHIP ||
        kind == iafcc_pkg::IAFCC_K_BLOCK ||
        kind == iafcc_pkg::IAFCC_K_SECTOR);

    always_comb begin
        mem.eraseLo = '0;
        mem.eraseHi = '1;
        if (kind == iafcc_pkg::IAFCC_K_BLOCK) begin
            mem.eraseLo = selBlk1 ? blk1Base : '0;
            mem.eraseHi = selBlk1 ? '1 : blk1Base - 1'b1;
        end else if (kind == iafcc_pkg::IAFCC_K_SECTOR) begin
            mem.eraseLo = mboxAddr & secMask;
            mem.eraseHi = (mboxAddr & secMask) | ~secMask;
        end
    end

    // Code reads fail while any flash operation runs
    assign mem.rdEn = verifyCmd || (codeRdEn && !flashBusy);
    assign mem.rdAddr = verifyCmd ? mboxAddr : codeAddr;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            codeRdFail <= 1'b0;
            verifyLoad <= 1'b0;
        end else begin
            codeRdFail <= codeRdEn && (flashBusy || verifyCmd);
            verifyLoad <= verifyCmd;
        end
    end
    assign codeRdData = codeRdFail ? `IAFCC_ERASED : mem.rdData;

    // ==========================================================
    // Mailbox writes and non-volatile bits
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addrLow <= 8'h00;
            addrHigh <= 8'h00;
            configMbox <= 8'h00;
            cmdMbox <= 8'h00;
        end else if (regWrEn) begin
            if (regAddr == `IAFCC_OFF_ADDRL) begin
                addrLow <= regWrData;
            end else if (regAddr == `IAFCC_OFF_ADDRH) begin
                addrHigh <= regWrData;
            end else if (regAddr == `IAFCC_OFF_CONFIG) begin
                configMbox <= regWrData;
            end else if (regAddr == `IAFCC_OFF_CMD) begin
                cmdMbox <= regWrData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dataMbox <= 8'h00;
        end else if (verifyLoad) begin
            dataMbox <= mem.rdData;
        end else if (regWrEn && regAddr == `IAFCC_OFF_DATA) begin
            dataMbox <= regWrData;
        end
    end

    // Security and remap bits survive reset; chip erase clears both.
    // Power-up value marks the bits as not yet initialised.
    logic nvInit = 1'b0;
    always_ff @(posedge sys_clk) begin
        if (sys_rst && !nvInit) begin
            secBits <= 3'b000;
            remapBits <= 2'b00;
            nvInit <= 1'b1;
        end else if (opEnd && kind == iafcc_pkg::IAFCC_K_CHIP) begin
            secBits <= 3'b000;
            remapBits <= 2'b00;
        end else if (opEnd && kind == iafcc_pkg::IAFCC_K_SECBIT) begin
            secBits[0] <= secBits[0] | (cmdMbox[6:0] == `IAFCC_OP_SB1);
            secBits[1] <= secBits[1] | (cmdMbox[6:0] == `IAFCC_OP_SB2);
            secBits[2] <= secBits[2] | (cmdMbox[6:0] == `IAFCC_OP_SB3);
        end else if (opEnd && kind == iafcc_pkg::IAFCC_K_REMAP) begin
            remapBits[1] <= remapBits[1] | (cmdMbox[6:0] == `IAFCC_OP_RB1);
            remapBits[0] <= remapBits[0] | (cmdMbox[6:0] == `IAFCC_OP_RB0);
        end
    end

    // Mapping follows the remap bits only at reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mapEnable <= remapBits;
        end
    end

    // ==========================================================
    // Status and interrupt
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flashBusy <= 1'b0;
            byteBusy <= 1'b0;
            doneEvent <= 1'b0;
        end else begin
            flashBusy <= accept || (flashBusy &&
                state != iafcc_pkg::IAFCC_FINISH) ||
                (flashBusy && state == iafcc_pkg::IAFCC_IDLE && accept);
            byteBusy <= accept || burstNext ||
                (byteBusy && !timerDone);
            doneEvent <= state == iafcc_pkg::IAFCC_FINISH &&
                cmdMbox[`IAFCC_CMD_IRQ_SEL];
        end
    end

    // Edge pulse onto line B only with both enables and edge mode
    assign lineBInterrupt = doneEvent ? (lineBInterruptEnable &&
        globalInterruptEnable && lineBEdgeSelect) :
        (!cmdMbox[`IAFCC_CMD_IRQ_SEL] && externalInterruptLineB &&
        lineBInterruptEnable && globalInterruptEnable);
    assign lineBPinAsPort = cmdMbox[`IAFCC_CMD_IRQ_SEL];

    // ==========================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            if (regAddr == `IAFCC_OFF_STATUS) begin
                regRdData <= {secBits, 1'b0, byteBusy, flashBusy, 2'b00};
            end else if (regAddr == `IAFCC_OFF_CMD) begin
                regRdData <= cmdMbox;
            end else if (regAddr == `IAFCC_OFF_ADDRL) begin
                regRdData <= addrLow;
            end else if (regAddr == `IAFCC_OFF_ADDRH) begin
                regRdData <= addrHigh;
            end else if (regAddr == `IAFCC_OFF_DATA) begin
                regRdData <= dataMbox;
            end else if (regAddr == `IAFCC_OFF_CONFIG) begin
                regRdData <= configMbox;
            end else if (regAddr == `IAFCC_OFF_REMAP) begin
                regRdData <= {4'h0, mapEnable, remapBits};
            end else begin
                regRdData <= 8'h00;
            end
        end
    end
endmodule : iafcc_ctrl

// *** hw/iafcc_consts.svh ***
// Constants for the in-application flash command controller.
// Included by the controller, timer and array files; holds definitions only.
`ifndef IAFCC_CONSTS_SVH
`define IAFCC_CONSTS_SVH

// Mailbox register offsets
`define IAFCC_OFF_STATUS 8'h00
`define IAFCC_OFF_CMD 8'h01
`define IAFCC_OFF_ADDRL 8'h02
`define IAFCC_OFF_ADDRH 8'h03
`define IAFCC_OFF_DATA 8'h04
`define IAFCC_OFF_CONFIG 8'h05
`define IAFCC_OFF_REMAP 8'h06

// Field positions
`define IAFCC_CFG_IAP_EN 6
`define IAFCC_CMD_IRQ_SEL 7
`define IAFCC_ST_FLASH_BUSY 2
`define IAFCC_ST_BYTE_BUSY 3

// Command codes (low seven bits)
`define IAFCC_OP_CHIP_ERASE 7'h01
`define IAFCC_OP_BLOCK_ERASE 7'h0D
`define IAFCC_OP_SECTOR_ERASE 7'h0B
`define IAFCC_OP_BYTE_PROG 7'h0E
`define IAFCC_OP_BURST_PROG 7'h06
`define IAFCC_OP_VERIFY 7'h0C
`define IAFCC_OP_SB3 7'h05
`define IAFCC_OP_SB2 7'h03
`define IAFCC_OP_SB1 7'h0F
`define IAFCC_OP_RB1 7'h09
`define IAFCC_OP_RB0 7'h08

// Key values
`define IAFCC_KEY_DATA 8'h55
`define IAFCC_KEY_ADDRH 8'h80
`define IAFCC_BLK1_NIB 4'hF
`define IAFCC_ERASED 8'hFF

// Timing: 25 MHz clock, burst time-out 20 us, exactly 500 cycles
`define IAFCC_CLK_MHZ 25
`define IAFCC_BURST_TO_US 20
`define IAFCC_BURST_TO_CYC (`IAFCC_BURST_TO_US * `IAFCC_CLK_MHZ)

`endif

// *** hw/iafcc_pkg.sv ***
// Types shared by the flash command controller modules.
// Assumes iafcc_consts.svh for numeric constants.
package iafcc_pkg;
    typedef enum logic [2:0] {
        IAFCC_IDLE = 3'b000,
        IAFCC_EXEC = 3'b001,
        IAFCC_BURST_WAIT = 3'b010,
        IAFCC_BURST_PROG = 3'b011,
        IAFCC_FINISH = 3'b100
    } iafcc_state_t;

    typedef enum logic [2:0] {
        IAFCC_K_CHIP = 3'b000,
        IAFCC_K_BLOCK = 3'b001,
        IAFCC_K_SECTOR = 3'b010,
        IAFCC_K_BYTE = 3'b011,
        IAFCC_K_BURST = 3'b100,
        IAFCC_K_SECBIT = 3'b101,
        IAFCC_K_REMAP = 3'b110
    } iafcc_kind_t;
endpackage : iafcc_pkg

// *** hw/iafcc_mem_if.sv ***
// Interface from the sequencer to the flash array model.
// Assumes one clock domain, sys_clk.
`timescale 1ns/1ns
interface iafcc_mem_if #(parameter int AW = 16);
    logic rdEn;
    logic [AW-1:0] rdAddr;
    logic [7:0] rdData;
    logic wrEn;
    logic [AW-1:0] wrAddr;
    logic [7:0] wrData;
    logic eraseEn;
    logic [AW-1:0] eraseLo;
    logic [AW-1:0] eraseHi;
    modport seq (output rdEn, rdAddr, wrEn, wrAddr, wrData,
        eraseEn, eraseLo, eraseHi, input rdData);
    modport array (input rdEn, rdAddr, wrEn, wrAddr, wrData,
        eraseEn, eraseLo, eraseHi, output rdData);
endinterface : iafcc_mem_if

// *** hw/iafcc_osc_timer.sv ***
// Gated timing oscillator: counts only while enabled.
// Assumes enable is held for the whole operation.
`timescale 1ns/1ns
`include "iafcc_consts.svh"
module iafcc_osc_timer #(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic oscEn,
    input wire logic [W-1:0] target,
    output logic done,
    output logic running
);
    logic [W-1:0] count;

    // Counter stops and clears when the oscillator is off
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !oscEn) begin
            count <= '0;
        end else if (count != target) begin
            count <= count + 1'b1;
        end
    end

    assign done = oscEn && (count == target);
    assign running = oscEn;
endmodule : iafcc_osc_timer

// *** hw/iafcc_flash_array.sv ***
// Flash array storage: DEPTH bytes in flip-flops, indexed by low address bits only; byte write clears bits.
// Assumes at most one of write and erase per cycle.
`timescale 1ns/1ns
`include "iafcc_consts.svh"
module iafcc_flash_array #(
    parameter int AW = 16,
    parameter int DEPTH = 64
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    iafcc_mem_if.array mem
);
    logic [7:0] cells [DEPTH];
    localparam int IW = $clog2(DEPTH);

    function automatic logic [IW-1:0] idx(input logic [AW-1:0] a);
        idx = a[IW-1:0];
    endfunction : idx

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_cell
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    cells[gi] <= `IAFCC_ERASED;
                end else if (mem.eraseEn &&
                        IW'(gi) >= idx(mem.eraseLo) &&
                        IW'(gi) <= idx(mem.eraseHi)) begin
                    cells[gi] <= `IAFCC_ERASED;
                end else if (mem.wrEn && idx(mem.wrAddr) == IW'(gi)) begin
                    cells[gi] <= cells[gi] & mem.wrData;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mem.rdData <= 8'h00;
        end else if (mem.rdEn) begin
            mem.rdData <= cells[idx(mem.rdAddr)];
        end
    end
endmodule : iafcc_flash_array

// *** verif/iafcc_ctrl_chk.sv ***
// Concurrent checks on the flash command controller ports.
// Assumes one clock, sys_clk, and synchronous sys_rst.
`timescale 1ns/1ns
module iafcc_ctrl_chk #(
    parameter int AW = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic [AW-1:0] codeAddr,
    input wire logic codeRdEn,
    input wire logic [7:0] codeRdData,
    input wire logic codeRdFail,
    input wire logic lineBEdgeSelect,
    input wire logic lineBInterruptEnable,
    input wire logic globalInterruptEnable,
    input wire logic lineBInterrupt,
    input wire logic lineBPinAsPort,
    input wire logic [1:0] mapEnable,
    input wire logic oscEnable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic cfgEn;
    logic cmdWr;
    logic knownOp;
    assign cmdWr = regWrEn && regAddr == 8'h01;
    assign knownOp = regWrData[6:0] inside {7'h01, 7'h0D, 7'h0B, 7'h0E,
        7'h06, 7'h0C, 7'h05, 7'h03, 7'h0F, 7'h09, 7'h08};
    // Shadow of the enable bit in the configuration mailbox
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfgEn <= 1'b0;
        end else if (regWrEn && regAddr == 8'h05) begin
            cfgEn <= regWrData[6];
        end
    end
    ignore_disabled_a: assert property (cmdWr && !cfgEn && !oscEnable
        |=> !oscEnable [*2]) else $error("command ran while disabled");
    start_by_cmd_a: assert property ($rose(oscEnable) |-> $past(cmdWr)
        || $past(cmdWr, 2) || $past(cmdWr, 3))
        else $error("operation started without command");
    busy_status_a: assert property (regRdEn && regAddr == 8'h00 && oscEnable
        |=> regRdData[2]) else $error("busy flag low during operation");
    code_fail_a: assert property (codeRdEn && oscEnable
        && codeAddr[AW-1:AW-4] != 4'hF |=> codeRdFail)
        else $error("code read succeeded while busy");
    fail_data_a: assert property (codeRdFail |-> codeRdData == 8'hFF)
        else $error("failed code read returned data");
    irq_gate_a: assert property (lineBInterrupt |-> lineBInterruptEnable
        && globalInterruptEnable && lineBEdgeSelect)
        else $error("interrupt with enables clear");
    irq_source_a: assert property (lineBInterrupt |-> lineBPinAsPort
        && !oscEnable) else $error("interrupt without completion");
    irq_pulse_a: assert property (lineBInterrupt |=> !lineBInterrupt)
        else $error("interrupt longer than one cycle");
    map_hold_a: assert property ($stable(mapEnable))
        else $error("mapping changed outside reset");
    unknown_op_a: assert property (cmdWr && !knownOp && !oscEnable
        |=> !oscEnable [*2]) else $error("unknown code started");
    cov_busy_c: cover property ($rose(oscEnable));
    cov_irq_c: cover property (lineBInterrupt);
    cov_fail_c: cover property (codeRdFail);
endmodule : iafcc_ctrl_chk

// *** verif/iafcc_cpu_model.sv ***
// Firmware-side master model: mailbox writes and reads.
// Assumes it is the only driver of the register port.
`timescale 1ns/1ns
module iafcc_cpu_model (
    input wire logic sys_clk,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    // Released lines show the inverse so stale values are never reused
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        @(negedge sys_clk);
        d = regRdData;
    endtask : rd
endmodule : iafcc_cpu_model

// *** verif/test_in_app_flash_cmd_ctrl.sv ***
// Self-checking bench for the flash command controller.
// Assumes the design defaults: 25 cycle program, 100 cycle erase.
`timescale 1ns/1ns
module test_in_app_flash_cmd_ctrl;
    localparam int AW = 16;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr, regWrData, regRdData, codeRdData, st;
    logic regWrEn, regRdEn, codeRdFail, lineBInterrupt, lineBPinAsPort;
    logic [AW-1:0] codeAddr = 16'h0000;
    logic codeRdEn = 1'b0;
    logic lineBEdgeSelect = 1'b0;
    logic lineBInterruptEnable = 1'b0;
    logic globalInterruptEnable = 1'b0;
    logic externalInterruptLineB = 1'b0;
    logic [1:0] mapEnable, mapSeen;
    logic oscEnable;
    int mismatches = 0;
    int nCompared = 0;
    int irqCount = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (lineBInterrupt === 1'b1) irqCount++;
    iafcc_ctrl #(.AW(AW)) dut (.*);
    iafcc_cpu_model cpu (.*);
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic op(input logic [7:0] ah, al, d, c);
        cpu.wr(8'h02, al);
        cpu.wr(8'h03, ah);
        cpu.wr(8'h04, d);
        cpu.wr(8'h01, c);
    endtask : op
    task automatic busy(input logic [7:0] exp);
        cpu.rd(8'h00, st);
        check("busy", st & 8'h04, exp);
    endtask : busy
    task automatic wait_idle;
        repeat (300) begin
            cpu.rd(8'h00, st);
            if (st[2] === 1'b0) break;
        end
        check("idle", st & 8'h04, 8'h00);
    endtask : wait_idle
    task automatic verify(input logic [7:0] al, c, exp);
        op(8'h00, al, 8'h00, c);
        cpu.rd(8'h04, st);
        check("verify", st, exp);
    endtask : verify
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        op(8'h00, 8'h00, 8'hA5, 8'h0E);
        busy(8'h00);
        cpu.wr(8'h05, 8'h40);
        cpu.wr(8'h04, 8'h12);
        busy(8'h00);
        op(8'h00, 8'h00, 8'hA5, 8'h0E);
        busy(8'h04);
        @(posedge sys_clk);
        codeRdEn <= 1'b1;
        @(posedge sys_clk);
        codeRdEn <= 1'b0;
        @(negedge sys_clk);
        check("code fail", {7'h00, codeRdFail}, 8'h01);
        check("code data", codeRdData, 8'hFF);
        wait_idle();
        verify(8'h00, 8'h0C, 8'hA5);
        op(8'h00, 8'h00, 8'h00, 8'h7F);
        busy(8'h00);
        op(8'h00, 8'h00, 8'h00, 8'h01);
        busy(8'h00);
        lineBEdgeSelect <= 1'b1;
        lineBInterruptEnable <= 1'b1;
        globalInterruptEnable <= 1'b1;
        op(8'h00, 8'h01, 8'h3C, 8'h8E);
        @(negedge sys_clk);
        check("pin port", {7'h00, lineBPinAsPort}, 8'h01);
        wait_idle();
        check("irq", 8'(irqCount), 8'h01);
        verify(8'h01, 8'h8C, 8'h3C);
        check("irq verify", 8'(irqCount), 8'h01);
        globalInterruptEnable <= 1'b0;
        op(8'h00, 8'h02, 8'h0F, 8'h8E);
        wait_idle();
        check("irq masked", 8'(irqCount), 8'h01);
        op(8'h00, 8'h00, 8'h00, 8'h0B);
        busy(8'h04);
        wait_idle();
        verify(8'h02, 8'h0C, 8'hFF);
        mapSeen = mapEnable;
        op(8'h80, 8'h00, 8'h55, 8'h08);
        wait_idle();
        check("map", {6'h00, mapEnable}, {6'h00, mapSeen});
        op(8'h80, 8'h00, 8'h55, 8'h0F);
        wait_idle();
        op(8'h00, 8'h05, 8'h66, 8'h0E);
        busy(8'h00);
        op(8'h00, 8'h00, 8'h55, 8'h01);
        busy(8'h04);
        wait_idle();
        op(8'h00, 8'h05, 8'h66, 8'h0E);
        wait_idle();
        verify(8'h05, 8'h0C, 8'h66);
        verify(8'h01, 8'h0C, 8'hFF);
        end_of_test();
    end
endmodule : test_in_app_flash_cmd_ctrl
bind iafcc_ctrl iafcc_ctrl_chk #(.AW(AW)) chk (.*);
